//--- stab_pkg.sv
// constants, field positions and selection codes of the stabilization chain
// assumes a 10 MHz system clock and a byte-wide auxiliary serial port
`default_nettype none
package stab_pkg;
  localparam logic [6:0] ADDR_STATUS = 7'h1e;
  localparam logic [6:0] ADDR_INT_CFG = 7'h6f;
  localparam logic [6:0] ADDR_MAIN_CTRL = 7'h70;
  localparam logic [6:0] ADDR_FILTER = 7'h71;
  localparam logic [6:0] ADDR_ACCEL_ST = 7'h72;
  localparam logic [6:0] ADDR_GYRO_FIRST = 7'h22;
  localparam logic [6:0] ADDR_GYRO_LAST = 7'h27;
  localparam logic [6:0] ADDR_ACCEL_FIRST = 7'h28;
  localparam logic [6:0] ADDR_ACCEL_LAST = 7'h2d;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [7:0] MASK_INT_CFG = 8'hc0;
  localparam logic [7:0] MASK_FILTER = 8'h37;
  localparam int HP_SEL_LSB = 4;
  localparam int LP1_SEL_LSB = 1;
  localparam int HP_EN_BIT = 0;
  localparam int POL_BIT = 7;
  localparam int RANGE_LSB = 5;
  localparam int BW_LSB = 3;
  localparam int ST_LSB = 1;
  localparam int CLAMPDIS_BIT = 0;
  localparam int CHAIN_EN_BIT = 0;
  localparam int ACCEL_CHAIN_BIT = 4;
  localparam int WIRE3_BIT = 5;
  localparam logic [15:0] CLAMP_VALUE = 16'h8000;
  localparam logic [15:0] LIMIT_VALUE = 16'h8001;
  localparam int SNAP_BYTES = 17;
  localparam int SNAP_STATUS = 12;
  localparam int SNAP_CTRL = 13;
  localparam int CLK_HZ = 10000000;
  localparam int SETTLE_TIME_MS = 80;
  localparam int SETTLE_CYCLES = SETTLE_TIME_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {HP_CUT_0P016HZ, HP_CUT_0P065HZ, HP_CUT_0P260HZ, HP_CUT_1P04HZ} hp_cutoff_t;
  typedef enum logic [1:0] {LP1_BW_351HZ, LP1_BW_237HZ, LP1_BW_173HZ, LP1_BW_937HZ} lp1_bw_t;
  typedef enum logic [1:0] {RATE_POWER_DOWN, RATE_UPTO_800HZ, RATE_FROM_1600HZ} rate_class_t;
endpackage : stab_pkg
`default_nettype wire

//--- bit_sync.sv
// two-flop synchronizer for a group of independent levels
// assumes each bit is a level or a toggle, never a multi-bit word
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;
  sync_state_t r_reg, r_next;
  always_comb begin
    r_next.stage1 = async_in;
    r_next.stage2 = r_reg.stage1;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '{stage1: INIT, stage2: INIT};
    end else begin
      r_reg <= r_next;
    end
  end
  assign sync_out = r_reg.stage2;
endmodule : bit_sync
`default_nettype wire

//--- aux_link.sv
// auxiliary serial slave on the link clock: address byte (read flag first), then data
// assumes a frozen register snapshot while the frame runs and one write byte per frame
`default_nettype none
module aux_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic nrst,
  input wire logic sdi,
  input wire logic wire3,
  input wire logic [stab_pkg::SNAP_BYTES*8-1:0] snap,
  output logic sdo,
  output logic sdo_oe_n,
  output logic wr_tog,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic gyro_hi_tog,
  output logic accel_hi_tog
);
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic in_data;
    logic is_read;
    logic [6:0] addr;
    logic [6:0] shift;
    logic [7:0] tx;
    logic oe_n;
    logic wr_done;
    logic gyro_seen;
    logic accel_seen;
    logic [1:0] hi_pend;
  } frame_t;
  typedef struct packed {
    logic wr_tog;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic gyro_tog;
    logic accel_tog;
  } keep_t;
  frame_t f_reg, f_next;
  keep_t k_reg, k_next;
  function automatic logic [7:0] read_byte(input logic [6:0] a, input logic [stab_pkg::SNAP_BYTES*8-1:0] s);
    logic [6:0] idx;
    idx = 7'h00;
    if (a >= stab_pkg::ADDR_GYRO_FIRST && a <= stab_pkg::ADDR_ACCEL_LAST) begin
      idx = a - stab_pkg::ADDR_GYRO_FIRST;
    end else if (a == stab_pkg::ADDR_STATUS) begin
      idx = 7'(stab_pkg::SNAP_STATUS);
    end else if (a >= stab_pkg::ADDR_INT_CFG && a <= stab_pkg::ADDR_ACCEL_ST) begin
      idx = 7'(a - stab_pkg::ADDR_INT_CFG + 7'(stab_pkg::SNAP_CTRL));
    end else begin
      return 8'h00;
    end
    return s[idx*8 +: 8];
  endfunction : read_byte
  always_comb begin
    logic [7:0] byte_in;
    logic [6:0] ra;
    f_next = f_reg;
    k_next = k_reg;
    byte_in = {f_reg.shift, sdi};
    ra = f_reg.addr;
    f_next.shift = byte_in[6:0];
    f_next.bit_cnt = f_reg.bit_cnt + 3'h1;
    f_next.tx = {f_reg.tx[6:0], 1'b0};
    if (f_reg.bit_cnt == 3'h7) begin
      if (!f_reg.in_data) begin
        f_next.in_data = 1'b1;
        f_next.is_read = byte_in[7];
        f_next.addr = byte_in[6:0];
        ra = byte_in[6:0];
      end else if (f_reg.is_read) begin
        f_next.addr = f_reg.addr + 7'h01;
        ra = f_reg.addr + 7'h01;
      end else if (!f_reg.wr_done) begin
        f_next.wr_done = 1'b1;
        k_next.wr_tog = ~k_reg.wr_tog;
        k_next.wr_addr = f_reg.addr;
        k_next.wr_data = byte_in;
      end
      if ((f_reg.in_data && f_reg.is_read) || (!f_reg.in_data && byte_in[7])) begin
        f_next.tx = read_byte(ra, snap);
        f_next.oe_n = ~wire3;
        // a high byte is the odd address of each pair
        f_next.hi_pend[0] = ra[0] && ra >= stab_pkg::ADDR_GYRO_FIRST && ra <= stab_pkg::ADDR_GYRO_LAST;
        f_next.hi_pend[1] = ra[0] && ra >= stab_pkg::ADDR_ACCEL_FIRST && ra <= stab_pkg::ADDR_ACCEL_LAST;
      end
    end
    // the byte prefetched at the last edge of a frame is never sent, so only a shifted-out high byte counts
    if (f_reg.in_data && f_reg.is_read && f_reg.bit_cnt == 3'h0) begin
      if (f_reg.hi_pend[0] && !f_reg.gyro_seen) begin
        f_next.gyro_seen = 1'b1;
        k_next.gyro_tog = ~k_reg.gyro_tog;
      end
      if (f_reg.hi_pend[1] && !f_reg.accel_seen) begin
        f_next.accel_seen = 1'b1;
        k_next.accel_tog = ~k_reg.accel_tog;
      end
    end
  end
  // frame state dies with chip select since the link clock stops between frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      f_reg <= '{oe_n: 1'b1, default: '0};
    end else begin
      f_reg <= f_next;
    end
  end
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      k_reg <= '0;
    end else begin
      k_reg <= k_next;
    end
  end
  assign sdo = f_reg.tx[7];
  assign sdo_oe_n = f_reg.oe_n;
  assign wr_tog = k_reg.wr_tog;
  assign wr_addr = k_reg.wr_addr;
  assign wr_data = k_reg.wr_data;
  assign gyro_hi_tog = k_reg.gyro_tog;
  assign accel_hi_tog = k_reg.accel_tog;
endmodule : aux_link
`default_nettype wire

//--- stab_chain_aux_port.sv
// stabilization chain control, status and auxiliary port view
// assumes sensor samples arrive on clk; the auxiliary port runs on its own clock
//
// How it works
// - filter bits 5:4 pick gyro high-pass cutoff 0.016/0.065/0.260/1.04 Hz.
// - filter bits 2:1 pick first low-pass bandwidth 351/237/173/937 Hz.
// - stabilization modes 3 or 4 take first low-pass from main gyro chain.
// - stabilization high-pass runs only when enabled and main high-pass off.
// - accel register bit 7 sets gate input polarity, 1 active high.
// - own accel range acts only with main accel off; else follows main range.
// - bits 4:3 with main accel rate class select accel bandwidth.
// - mode 4 removes second low-pass and high-pass from main accel chain.
// - accel register bits 2:1 select gyro stabilization self-test.
// - self-test with clamp enabled makes every auxiliary gyro output 8000h.
// - self-test with clamp disabled shows raw self-test variation on auxiliary port.
// - normal gyro outputs never reach 8000h, so it marks self-test.
// - status bit 2 stays high through gyro settling; host discards those samples.
// - status bit 1 sets on new gyro sample, clears on high-byte read.
// - status bit 0 sets on new accel sample, clears on high-byte read.
// - only the four stabilization registers are written, and only from auxiliary port.
// - chain enable starts mode 3 and exposes gyro bytes on auxiliary port.
// - chain plus accel-chain enable starts mode 4 and exposes accel bytes.
// - data bytes and status differ per port; other registers read alike.
`default_nettype none
module stab_chain_aux_port #(
  parameter int unsigned SETTLE_CYCLES = stab_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic aux_sclk,
  input wire logic aux_cs_n,
  input wire logic aux_sdx_in,
  output logic aux_sdx_out,
  output logic aux_sdx_oe_n,
  output logic aux_sdo,
  input wire logic data_gate_input,
  input wire logic gyro_sample_valid,
  input wire logic [47:0] gyro_sample,
  input wire logic accel_sample_valid,
  input wire logic [47:0] accel_sample,
  input wire logic main_gyro_hp_enable,
  input wire logic main_gyro_selftest,
  input wire logic main_accel_powered_down,
  input wire logic main_accel_rate_high,
  input wire logic [1:0] main_accel_range,
  output logic [7:0] int_cfg_ro,
  output logic [7:0] stab_main_ctrl_ro,
  output logic [7:0] stab_gyro_filter_ctrl_ro,
  output logic [7:0] stab_accel_selftest_ctrl_ro,
  output logic [1:0] stab_hp_cutoff_sel,
  output logic [1:0] stab_lp1_bw_sel,
  output logic stab_hp_active,
  output logic main_gyro_lp1_avail,
  output logic gate_active,
  output logic [1:0] stab_accel_range_sel,
  output logic [1:0] accel_rate_class,
  output logic [1:0] stab_accel_bw_sel,
  output logic main_accel_lp2_avail,
  output logic main_accel_hp_avail,
  output logic [1:0] stab_selftest_sel,
  output logic [47:0] aux_gyro_out,
  output logic [47:0] aux_accel_out,
  output logic [7:0] aux_port_status
);
  typedef struct packed {
    logic [7:0] int_cfg;
    logic [7:0] main_ctrl;
    logic [7:0] filter;
    logic [7:0] accel_st;
    logic rate_sample_new;
    logic accel_sample_new;
    logic settling;
    logic [19:0] settle_cnt;
    logic chain_prev;
    logic [2:0][15:0] gyro;
    logic [2:0][15:0] accel;
    logic [stab_pkg::SNAP_BYTES*8-1:0] snap;
    logic [2:0] tog_prev;
    logic hp_active;
    logic lp1_avail;
    logic gate;
    logic [1:0] range;
    logic [1:0] rate_class;
    logic lp2_avail;
    logic hp_xl_avail;
  } top_state_t;
  top_state_t r_reg, r_next;
  logic link_sdo, link_oe_n, link_wr_tog, link_gyro_tog, link_accel_tog;
  logic [6:0] link_wr_addr;
  logic [7:0] link_wr_data;
  logic [4:0] sync_q;
  logic cs_idle, gate_in, wr_evt, gyro_hi_evt, accel_hi_evt;
  logic chain_en, mode4, selftest_on;
  aux_link link (
    .sclk(aux_sclk),
    .cs_n(aux_cs_n),
    .nrst(nrst),
    .sdi(aux_sdx_in),
    .wire3(r_reg.main_ctrl[stab_pkg::WIRE3_BIT]),
    .snap(r_reg.snap),
    .sdo(link_sdo),
    .sdo_oe_n(link_oe_n),
    .wr_tog(link_wr_tog),
    .wr_addr(link_wr_addr),
    .wr_data(link_wr_data),
    .gyro_hi_tog(link_gyro_tog),
    .accel_hi_tog(link_accel_tog)
  );
  // chip select syncs to idle so the snapshot stays frozen only inside frames
  bit_sync #(.WIDTH(5), .INIT(5'h01)) sync (
    .clk(clk),
    .nrst(nrst),
    .async_in({data_gate_input, link_accel_tog, link_gyro_tog, link_wr_tog, aux_cs_n}),
    .sync_out(sync_q)
  );
  assign cs_idle = sync_q[0];
  assign gate_in = sync_q[4];
  assign wr_evt = sync_q[1] ^ r_reg.tog_prev[0];
  assign gyro_hi_evt = sync_q[2] ^ r_reg.tog_prev[1];
  assign accel_hi_evt = sync_q[3] ^ r_reg.tog_prev[2];
  assign chain_en = r_reg.main_ctrl[stab_pkg::CHAIN_EN_BIT];
  assign mode4 = chain_en & r_reg.main_ctrl[stab_pkg::ACCEL_CHAIN_BIT];
  assign selftest_on = main_gyro_selftest | (r_reg.accel_st[stab_pkg::ST_LSB +: 2] != 2'h0);
  always_comb begin
    r_next = r_reg;
    r_next.tog_prev = sync_q[3:1];
    r_next.chain_prev = chain_en;
    // only the auxiliary port reaches these; the primary side sees copies
    if (wr_evt) begin
      case (link_wr_addr)
        stab_pkg::ADDR_INT_CFG: r_next.int_cfg = link_wr_data & stab_pkg::MASK_INT_CFG;
        stab_pkg::ADDR_MAIN_CTRL: r_next.main_ctrl = link_wr_data;
        stab_pkg::ADDR_FILTER: r_next.filter = link_wr_data & stab_pkg::MASK_FILTER;
        stab_pkg::ADDR_ACCEL_ST: r_next.accel_st = link_wr_data;
        default: r_next.int_cfg = r_reg.int_cfg;
      endcase
    end
    if (chain_en && !r_reg.chain_prev) begin
      r_next.settling = 1'b1;
      r_next.settle_cnt = 20'(SETTLE_CYCLES - 1);
    end else if (!chain_en) begin
      r_next.settling = 1'b0;
    end else if (r_reg.settle_cnt != 20'h0) begin
      r_next.settle_cnt = r_reg.settle_cnt - 20'h1;
    end else begin
      r_next.settling = 1'b0;
    end
    // a sample in the same cycle as a high-byte read keeps its flag
    if (gyro_hi_evt) begin
      r_next.rate_sample_new = 1'b0;
    end
    if (accel_hi_evt) begin
      r_next.accel_sample_new = 1'b0;
    end
    if (gyro_sample_valid && chain_en) begin
      r_next.rate_sample_new = 1'b1;
      for (int i = 0; i < 3; i++) begin
        if (selftest_on && !r_reg.accel_st[stab_pkg::CLAMPDIS_BIT]) begin
          r_next.gyro[i] = stab_pkg::CLAMP_VALUE;
        end else if (selftest_on) begin
          r_next.gyro[i] = gyro_sample[16*i +: 16];
        end else if (gyro_sample[16*i +: 16] == stab_pkg::CLAMP_VALUE) begin
          r_next.gyro[i] = stab_pkg::LIMIT_VALUE;
        end else begin
          r_next.gyro[i] = gyro_sample[16*i +: 16];
        end
      end
    end
    if (accel_sample_valid && mode4) begin
      r_next.accel_sample_new = 1'b1;
      r_next.accel = accel_sample;
    end
    // snapshot changes only between frames; the link reads it without handshake
    if (cs_idle) begin
      r_next.snap[0 +: 48] = chain_en ? r_reg.gyro : 48'h0;
      r_next.snap[48 +: 48] = mode4 ? r_reg.accel : 48'h0;
      r_next.snap[stab_pkg::SNAP_STATUS*8 +: 8] = {5'h00, r_reg.settling, r_reg.rate_sample_new, r_reg.accel_sample_new};
      r_next.snap[stab_pkg::SNAP_CTRL*8 +: 32] = {r_reg.accel_st, r_reg.filter, r_reg.main_ctrl, r_reg.int_cfg};
    end
    r_next.hp_active = r_reg.filter[stab_pkg::HP_EN_BIT] & ~main_gyro_hp_enable;
    r_next.lp1_avail = ~chain_en;
    r_next.gate = gate_in ~^ r_reg.accel_st[stab_pkg::POL_BIT];
    r_next.range = main_accel_powered_down ? r_reg.accel_st[stab_pkg::RANGE_LSB +: 2] : main_accel_range;
    if (main_accel_powered_down) begin
      r_next.rate_class = stab_pkg::RATE_POWER_DOWN;
    end else if (main_accel_rate_high) begin
      r_next.rate_class = stab_pkg::RATE_FROM_1600HZ;
    end else begin
      r_next.rate_class = stab_pkg::RATE_UPTO_800HZ;
    end
    r_next.lp2_avail = ~mode4;
    r_next.hp_xl_avail = ~mode4;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r_reg <= '{int_cfg: stab_pkg::RESET_CTRL, main_ctrl: stab_pkg::RESET_CTRL, filter: stab_pkg::RESET_CTRL,
                 accel_st: stab_pkg::RESET_CTRL, lp1_avail: 1'b1, lp2_avail: 1'b1, hp_xl_avail: 1'b1,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end
  assign aux_sdx_out = link_sdo;
  assign aux_sdx_oe_n = link_oe_n;
  assign aux_sdo = link_sdo;
  assign int_cfg_ro = r_reg.int_cfg;
  assign stab_main_ctrl_ro = r_reg.main_ctrl;
  assign stab_gyro_filter_ctrl_ro = r_reg.filter;
  assign stab_accel_selftest_ctrl_ro = r_reg.accel_st;
  assign stab_hp_cutoff_sel = r_reg.filter[stab_pkg::HP_SEL_LSB +: 2];
  assign stab_lp1_bw_sel = r_reg.filter[stab_pkg::LP1_SEL_LSB +: 2];
  assign stab_hp_active = r_reg.hp_active;
  assign main_gyro_lp1_avail = r_reg.lp1_avail;
  assign gate_active = r_reg.gate;
  assign stab_accel_range_sel = r_reg.range;
  assign accel_rate_class = r_reg.rate_class;
  assign stab_accel_bw_sel = r_reg.accel_st[stab_pkg::BW_LSB +: 2];
  assign main_accel_lp2_avail = r_reg.lp2_avail;
  assign main_accel_hp_avail = r_reg.hp_xl_avail;
  assign stab_selftest_sel = r_reg.accel_st[stab_pkg::ST_LSB +: 2];
  assign aux_gyro_out = r_reg.gyro;
  assign aux_accel_out = r_reg.accel;
  assign aux_port_status = {5'h00, r_reg.settling, r_reg.rate_sample_new, r_reg.accel_sample_new};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_gda_sets: assert property ((gyro_sample_valid && chain_en) |=> aux_port_status[1])
    else $error("new gyro sample did not set its flag");
  a_gda_clears: assert property ((gyro_hi_evt && !gyro_sample_valid && chain_en) |=> !aux_port_status[1])
    else $error("gyro flag survived a high-byte read");
  a_accel_sample_new_sets: assert property ((accel_sample_valid && mode4) ##1 !accel_hi_evt |-> aux_port_status[0])
    else $error("new accel sample did not set its flag");
  a_settle_hold: assert property ($rose(chain_en) |=> aux_port_status[2] [*8])
    else $error("settling flag dropped early");
  a_hp_gating: assert property (##1 stab_hp_active == $past(stab_gyro_filter_ctrl_ro[0] && !main_gyro_hp_enable))
    else $error("stabilization high-pass gating wrong");
  a_lp1_taken: assert property (chain_en |-> ##1 !main_gyro_lp1_avail)
    else $error("first low-pass still offered to main chain");
  a_accel_filters: assert property (mode4 |=> (!main_accel_lp2_avail && !main_accel_hp_avail))
    else $error("main accel filters offered in mode 4");
  a_range_follow: assert property (!main_accel_powered_down |=> stab_accel_range_sel == $past(main_accel_range))
    else $error("accel range did not follow main chain");
  a_clamp_value: assert property ((gyro_sample_valid && chain_en && selftest_on && !r_reg.accel_st[0])
    |=> aux_gyro_out == {3{stab_pkg::CLAMP_VALUE}})
    else $error("self-test clamp value missing");
  a_limit_normal: assert property ((gyro_sample_valid && chain_en && !selftest_on) |=> (aux_gyro_out[15:0] != stab_pkg::CLAMP_VALUE
    && aux_gyro_out[31:16] != stab_pkg::CLAMP_VALUE && aux_gyro_out[47:32] != stab_pkg::CLAMP_VALUE))
    else $error("normal gyro output reached clamp value");
  a_filter_zero: assert property (stab_gyro_filter_ctrl_ro[7:6] == 2'h0 && stab_gyro_filter_ctrl_ro[3] == 1'b0)
    else $error("fixed-zero filter bits set");
endmodule : stab_chain_aux_port
`default_nettype wire

//--- stab_host_model.sv
// auxiliary serial master standing in for the external stabilization controller
// assumes the bench resolves the shared data line from both enables
`default_nettype none
module stab_host_model (
  output logic sclk,
  output logic cs_n,
  output logic m_d,
  output logic m_oe,
  input wire logic line,
  input wire logic sdo,
  input wire logic w3
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b0;
    m_d = 1'b0;
    m_oe = 1'b1;
    // a real rising chip select clears the slave's frame state before any frame
    #10;
    cs_n = 1'b1;
  end
  // header byte then n data bytes; clock stands high outside frames
  task automatic frame(input logic [7:0] hdr, input logic [7:0] wd, input int n, output logic [47:0] q);
    logic [7:0] sh;
    q = '0;
    sh = hdr;
    cs_n = 1'b0;
    // the slave freezes its snapshot before the first edge
    #400;
    for (int i = 0; i < 8 * (n + 1); i++) begin
      if (i == 8) begin
        sh = wd;
        m_oe = !hdr[7];
      end
      sclk = 1'b0;
      m_d = sh[7];
      #6;
      // read bits taken late in the low phase, long after the slave's rising-edge update
      if (i >= 8) q = {q[46:0], w3 ? line : sdo};
      sclk = 1'b1;
      sh = {sh[6:0], 1'b0};
      #6;
    end
    cs_n = 1'b1;
    m_oe = 1'b1;
    #600;
  endtask : frame
endmodule : stab_host_model
`default_nettype wire

//--- stab_chain_aux_port_tb.sv
// self-checking bench: stabilization chain driven through its auxiliary serial port
// assumes sensor-side inputs change on falling clk and the host model owns the link pins
`default_nettype none
module stab_chain_aux_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic aux_sclk, aux_cs_n, m_d, m_oe, aux_sdx_out, aux_sdx_oe_n, aux_sdo;
  logic w3 = 1'b0;
  logic data_gate_input = 1'b0, gyro_sample_valid = 1'b0, accel_sample_valid = 1'b0, main_gyro_hp_enable = 1'b0;
  logic main_gyro_selftest = 1'b0, main_accel_powered_down = 1'b1, main_accel_rate_high = 1'b0;
  logic [1:0] main_accel_range = 2'h0;
  logic [47:0] gyro_sample = '0, accel_sample = '0;
  logic [7:0] int_cfg_ro, stab_main_ctrl_ro, stab_gyro_filter_ctrl_ro, stab_accel_selftest_ctrl_ro, aux_port_status;
  logic [1:0] stab_hp_cutoff_sel, stab_lp1_bw_sel, stab_accel_range_sel, accel_rate_class, stab_accel_bw_sel;
  logic [1:0] stab_selftest_sel;
  logic stab_hp_active, main_gyro_lp1_avail, gate_active, main_accel_lp2_avail, main_accel_hp_avail;
  logic [47:0] aux_gyro_out, aux_accel_out, q;
  int error_cnt = 0;
  int checks_done = 0;
  // a released line shows the inverse of the last driven bit, never a stale copy
  wire logic sdx_line = !aux_sdx_oe_n ? aux_sdx_out : (m_oe ? m_d : !m_d);
  always #50 clk = ~clk;
  stab_chain_aux_port #(.SETTLE_CYCLES(20)) u_dut (
    .clk, .nrst, .aux_sclk, .aux_cs_n, .aux_sdx_in(sdx_line), .aux_sdx_out, .aux_sdx_oe_n, .aux_sdo,
    .data_gate_input, .gyro_sample_valid, .gyro_sample, .accel_sample_valid, .accel_sample,
    .main_gyro_hp_enable, .main_gyro_selftest, .main_accel_powered_down, .main_accel_rate_high,
    .main_accel_range, .int_cfg_ro, .stab_main_ctrl_ro, .stab_gyro_filter_ctrl_ro, .stab_accel_selftest_ctrl_ro,
    .stab_hp_cutoff_sel, .stab_lp1_bw_sel, .stab_hp_active, .main_gyro_lp1_avail, .gate_active,
    .stab_accel_range_sel, .accel_rate_class, .stab_accel_bw_sel, .main_accel_lp2_avail, .main_accel_hp_avail,
    .stab_selftest_sel, .aux_gyro_out, .aux_accel_out, .aux_port_status
  );
  stab_host_model u_host (
    .sclk(aux_sclk), .cs_n(aux_cs_n), .m_d, .m_oe, .line(sdx_line), .sdo(aux_sdo), .w3
  );
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame({1'b0, a}, d, 1, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, input int n, input logic [47:0] exp);
    u_host.frame({1'b1, a}, 8'h00, n, q);
    chk(q, exp);
  endtask : rd
  task automatic smp(input logic g, input logic a, input logic [47:0] v);
    cyc(1);
    gyro_sample = v;
    accel_sample = v;
    gyro_sample_valid = g;
    accel_sample_valid = a;
    cyc(1);
    gyro_sample_valid = 1'b0;
    accel_sample_valid = 1'b0;
    cyc(2);
  endtask : smp
  task automatic run_all;
    cyc(12);
    nrst = 1'b1;
    cyc(4);
    chk(48'({int_cfg_ro, stab_main_ctrl_ro, stab_gyro_filter_ctrl_ro}), 48'h0);
    chk(48'({main_gyro_lp1_avail, main_accel_lp2_avail, main_accel_hp_avail}), 48'h7);
    rd(7'h70, 3, 48'h0);
    wr(7'h6f, 8'hff);
    wr(7'h1e, 8'hff);
    wr(7'h10, 8'hff);
    chk(48'(int_cfg_ro), 48'hc0);
    rd(7'h6f, 1, 48'hc0);
    rd(7'h10, 1, 48'h0);
    rd(7'h1e, 1, 48'h0);
    for (int c = 0; c < 4; c++) begin
      wr(7'h71, {2'h3, c[1:0], 1'b1, c[1:0], 1'b1});
      chk(48'(stab_hp_cutoff_sel), 48'(c));
      chk(48'(stab_lp1_bw_sel), 48'(c));
      rd(7'h71, 1, 48'({2'h0, c[1:0], 1'b0, c[1:0], 1'b1}));
      chk(48'(stab_gyro_filter_ctrl_ro), 48'({2'h0, c[1:0], 1'b0, c[1:0], 1'b1}));
    end
    chk(48'(stab_hp_active), 48'h1);
    cyc(1);
    main_gyro_hp_enable = 1'b1;
    cyc(3);
    chk(48'(stab_hp_active), 48'h0);
    wr(7'h72, 8'hf2);
    chk(48'(stab_accel_bw_sel), 48'h2);
    chk(48'(stab_selftest_sel), 48'h1);
    chk(48'(stab_accel_selftest_ctrl_ro), 48'hf2);
    chk(48'({stab_accel_range_sel, accel_rate_class}), 48'hc);
    cyc(1);
    main_accel_powered_down = 1'b0;
    main_accel_range = 2'h1;
    main_accel_rate_high = 1'b1;
    cyc(3);
    chk(48'({stab_accel_range_sel, accel_rate_class}), 48'h6);
    main_accel_rate_high = 1'b0;
    cyc(3);
    chk(48'(accel_rate_class), 48'h1);
    chk(48'(gate_active), 48'h0);
    data_gate_input = 1'b1;
    cyc(5);
    chk(48'(gate_active), 48'h1);
    wr(7'h72, 8'h00);
    chk(48'(gate_active), 48'h0);
    // main first low-pass is withdrawn as soon as the chain comes up
    wr(7'h70, 8'h21);
    w3 = 1'b1;
    chk(48'(main_gyro_lp1_avail), 48'h0);
    rd(7'h1e, 1, 48'h4);
    for (int i = 0; i < 100 && aux_port_status[2]; i++) cyc(1);
    if (aux_port_status[2] !== 1'b0) begin
      error_cnt++;
      $display("Error at %0t: settling flag never cleared", $time);
      return;
    end
    smp(1'b1, 1'b1, 48'h8000_1234_7fff);
    chk(aux_gyro_out, 48'h8001_1234_7fff);
    rd(7'h1e, 1, 48'h2);
    rd(7'h22, 6, 48'hff7f_3412_0180);
    chk(48'(aux_sdx_oe_n), 48'h1);
    rd(7'h1e, 1, 48'h0);
    rd(7'h28, 2, 48'h0);
    cyc(1);
    main_gyro_selftest = 1'b1;
    smp(1'b1, 1'b0, 48'h0300_0200_0100);
    chk(aux_gyro_out, 48'h8000_8000_8000);
    rd(7'h26, 2, 48'h0080);
    wr(7'h72, 8'h01);
    smp(1'b1, 1'b0, 48'h3333_2222_1111);
    chk(aux_gyro_out, 48'h3333_2222_1111);
    main_gyro_selftest = 1'b0;
    wr(7'h72, 8'h04);
    smp(1'b1, 1'b0, 48'h0300_0200_0100);
    chk(aux_gyro_out, 48'h8000_8000_8000);
    wr(7'h70, 8'h31);
    wr(7'h72, 8'h00);
    chk(48'({main_accel_lp2_avail, main_accel_hp_avail}), 48'h0);
    smp(1'b1, 1'b1, 48'h6655_4433_2211);
    chk(aux_accel_out, 48'h6655_4433_2211);
    rd(7'h1e, 1, 48'h3);
    rd(7'h29, 1, 48'h22);
    rd(7'h1e, 1, 48'h2);
    rd(7'h28, 6, 48'h1122_3344_5566);
    rd(7'h27, 1, 48'h66);
    rd(7'h1e, 1, 48'h0);
    cyc(1);
    nrst = 1'b0;
    cyc(3);
    nrst = 1'b1;
    cyc(4);
    chk(48'({stab_main_ctrl_ro, aux_port_status}), 48'h0);
    chk(48'({main_gyro_lp1_avail, main_accel_lp2_avail, main_accel_hp_avail}), 48'h7);
  endtask : run_all
  initial begin
    run_all();
    summarize();
  end
endmodule : stab_chain_aux_port_tb
`default_nettype wire
